// ### hdl/flash_cache_pkg.sv
// Purpose: shared constants and types for the flash prefetch cache control block
// Assumes: one system clock, APB register access with 32-bit data
// Notes:   offsets are byte addresses of aligned words
package flash_cache_pkg;
    // register byte offsets
    localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET  = 8'h04;
    localparam logic [7:0]  LOCK_OFFSET    = 8'h08;
    // control register field positions
    localparam int          COH_BIT        = 16;
    localparam int          DSIZE_LSB      = 8;
    localparam int          PFSEL_LSB      = 4;
    localparam int          WAIT_LSB       = 0;
    localparam logic [31:0] CTRL_WR_MASK   = 32'h0001_0337;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0007;
    localparam logic [31:0] LOCK_RESET     = 32'h0000_0000;
    // status register field positions
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_VALID_LSB = 4;
    // data line count codes
    localparam logic [1:0]  DSIZE_OFF      = 2'h0;
    localparam logic [1:0]  DSIZE_ONE      = 2'h1;
    localparam logic [1:0]  DSIZE_TWO      = 2'h2;
    localparam logic [1:0]  DSIZE_FOUR     = 2'h3;
    localparam logic [3:0]  DLINES_OFF     = 4'h0;
    localparam logic [3:0]  DLINES_ONE     = 4'h1;
    localparam logic [3:0]  DLINES_TWO     = 4'h3;
    localparam logic [3:0]  DLINES_FOUR    = 4'hF;
    // cache geometry
    localparam int          ILINES         = 4;
    localparam int          DLINES         = 4;
    localparam int          NLINES         = ILINES + DLINES;
    localparam int          TAG_W          = 30;
    localparam int          WORD_W         = 32;
    localparam logic [29:0] TAG_ONE        = 30'h0000_0001;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_FILL     = 2'b01,
        ST_PREFETCH = 2'b10
    } fetch_state_t;
endpackage

// ### hdl/flash_wait_timer.sv
// Purpose: counts the wait states of one program flash access
// Assumes: start is a one-cycle pulse, wait count steady during the access
// Notes:   access lasts wait count + 1 cycles; abort drops it without done
`timescale 1ns/1ns
module flash_wait_timer (
    input  wire logic       clk_i,      // system clock
    input  wire logic       rst_n_i,    // synchronous reset, active low
    input  wire logic       start_i,    // begin an access
    input  wire logic       abort_i,    // cancel the access
    input  wire logic [2:0] wait_i,     // wait states to insert
    output logic            busy_o,     // access in progress
    output logic            done_o      // last cycle of the access
);
    logic [2:0] count;

    // load on start, count down to zero, then finish
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || abort_i) begin
            busy_o <= 1'b0;
            count  <= 3'h0;
        end else if (start_i) begin
            busy_o <= 1'b1;
            count  <= wait_i;
        end else if (busy_o && count != 3'h0) begin
            count  <= count - 3'h1;
        end else if (busy_o) begin
            busy_o <= 1'b0;
        end
    end

    assign done_o = busy_o && (count == 3'h0) && !abort_i;
endmodule

// ### hdl/cache_line_slot.sv
// Purpose: one cache line holding a single word, its tag and valid bit
// Assumes: fill and invalidate never requested together for one line
// Notes:   invalidate wins over fill so a stale fill is never kept
`timescale 1ns/1ns
module cache_line_slot #(
    parameter int TW = 30,
    parameter int DW = 32
) (
    input  wire logic          clk_i,     // system clock
    input  wire logic          rst_n_i,   // synchronous reset, active low
    input  wire logic          inval_i,   // drop the line
    input  wire logic          fill_i,    // store a new word
    input  wire logic [TW-1:0] tag_i,     // tag to store
    input  wire logic [DW-1:0] data_i,    // word to store
    input  wire logic [TW-1:0] look_i,    // tag being looked up
    output logic               valid_o,   // line holds a word
    output logic               hit_o,     // lookup matches
    output logic [DW-1:0]      data_o     // stored word
);
    logic [TW-1:0] tag;

    // valid bit: invalidate has priority
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || inval_i) begin
            valid_o <= 1'b0;
        end else if (fill_i) begin
            valid_o <= 1'b1;
        end
    end

    // tag and data hold no control meaning, so no reset
    always_ff @(posedge clk_i) begin
        if (fill_i) begin
            tag    <= tag_i;
            data_o <= data_i;
        end
    end

    assign hit_o = valid_o && (tag == look_i);
endmodule

// ### hdl/flash_prefetch_cache.sv
// Purpose: cache and predictive prefetch control between core fetch port and program flash
// Assumes: core holds a fetch request until it sees FETCH_READY_O; flash data valid
//          on the last wait-state cycle of an access
// Notes:   one-word lines, four instruction lines and up to four data lines
`timescale 1ns/1ns
// Summary of operation
// - coherency bit one: program cycle invalidates all lines, locked ones too
// - coherency bit zero: program cycle keeps locked instruction lines, drops the rest
// - data size field selects four, two, one or no data lines
// - a write that changes the data size field invalidates every line
// - prefetch field enables prefetch for cacheable, non-cacheable, both or none
// - wait field gives zero to seven wait states per flash access
// - reset loads wait field with all ones, other fields zero
module flash_prefetch_cache
    import flash_cache_pkg::*;
(
    input  wire logic        CLOCK_I,            // system clock, 25 MHz
    input  wire logic        RSTN_I,             // synchronous reset, active low
    input  wire logic        PSEL_I,             // apb select
    input  wire logic        PENABLE_I,          // apb access phase
    input  wire logic        PWRITE_I,           // apb direction
    input  wire logic [7:0]  PADDR_I,            // apb byte address
    input  wire logic [31:0] PWDATA_I,           // apb write data
    output logic [31:0]      PRDATA_O,           // apb read data
    output logic             PREADY_O,           // apb ready
    output logic             PSLVERR_O,          // apb error, unmapped address
    input  wire logic        FETCH_REQ_I,        // core fetch request
    input  wire logic [31:0] FETCH_ADDR_I,       // core fetch byte address
    input  wire logic        FETCH_DATA_I,       // 1 data access, 0 instruction
    input  wire logic        FETCH_CACHEABLE_I,  // address lies in a cacheable region
    output logic             FETCH_READY_O,      // one-cycle answer pulse
    output logic [31:0]      FETCH_RDATA_O,      // fetched word
    output logic             FLASH_REQ_O,        // program flash read in progress
    output logic [31:0]      FLASH_ADDR_O,       // program flash byte address
    input  wire logic [31:0] FLASH_RDATA_I,      // program flash read data
    input  wire logic        PROG_CYCLE_I        // program flash program cycle pulse
);
    logic [31:0]       ctrl;
    logic [3:0]        lock;
    fetch_state_t      state;
    logic              apb_fire;
    logic              wr_ctrl;
    logic              size_change;
    logic              inval_any;
    logic [NLINES-1:0] inval_vec;
    logic [NLINES-1:0] fill_vec;
    logic [NLINES-1:0] line_valid;
    logic [NLINES-1:0] line_hit;
    logic [WORD_W-1:0] line_data [NLINES];
    logic [3:0]        data_en;
    logic              coherency;
    logic [1:0]        dsize;
    logic [1:0]        pfsel;
    logic [2:0]        wait_cnt;
    logic [TAG_W-1:0]  look_tag;
    logic              cache_hit;
    logic [WORD_W-1:0] cache_word;
    logic              pf_valid;
    logic [TAG_W-1:0]  pf_tag;
    logic [WORD_W-1:0] pf_data;
    logic              pf_hit;
    logic              pf_allowed;
    logic              can_cache;
    logic [TAG_W-1:0]  miss_tag;
    logic              miss_data;
    logic              miss_cache;
    logic              miss_pf;
    logic [1:0]        iptr;
    logic [1:0]        dptr;
    logic              flash_start;
    logic              flash_done;
    logic              accept;
    logic [31:0]       next_rdata;
    logic              next_err;

    assign coherency = ctrl[COH_BIT];
    assign dsize     = ctrl[DSIZE_LSB +: 2];
    assign pfsel     = ctrl[PFSEL_LSB +: 2];
    assign wait_cnt  = ctrl[WAIT_LSB +: 3];

    // apb: access phase gets pready one cycle late, writes land at the pready edge
    assign apb_fire    = PSEL_I && PENABLE_I && PREADY_O;
    assign wr_ctrl     = apb_fire && PWRITE_I && (PADDR_I == CTRL_OFFSET);
    assign size_change = wr_ctrl && (PWDATA_I[DSIZE_LSB +: 2] != dsize);

    // read data and error decided at the start of the access phase
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (PADDR_I == CTRL_OFFSET) begin
            next_rdata = ctrl;
        end else if (PADDR_I == STATUS_OFFSET) begin
            next_rdata[STAT_BUSY_BIT] = (state != ST_IDLE);
            next_rdata[STAT_VALID_LSB +: NLINES] = line_valid;
        end else if (PADDR_I == LOCK_OFFSET) begin
            next_rdata[3:0] = lock;
        end else begin
            next_err = 1'b1;
        end
    end

    // apb answer flops
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
            PREADY_O  <= 1'b1;
            PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : next_rdata;
            PSLVERR_O <= next_err;
        end else begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
    end

    // control register; unimplemented bits are masked off and read zero
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= PWDATA_I & CTRL_WR_MASK;
        end
    end

    // instruction line lock register
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            lock <= LOCK_RESET[3:0];
        end else if (apb_fire && PWRITE_I && PADDR_I == LOCK_OFFSET) begin
            lock <= PWDATA_I[3:0];
        end
    end

    // data lines in use for each size code
    always_comb begin
        case (dsize)
            DSIZE_ONE:  data_en = DLINES_ONE;
            DSIZE_TWO:  data_en = DLINES_TWO;
            DSIZE_FOUR: data_en = DLINES_FOUR;
            default:    data_en = DLINES_OFF;
        endcase
    end

    // invalidation: program cycle spares locked instruction lines unless coherency set
    always_comb begin
        inval_vec = '0;
        if (size_change) begin
            inval_vec = '1;
        end else if (PROG_CYCLE_I) begin
            inval_vec[NLINES-1:ILINES] = '1;
            inval_vec[ILINES-1:0] = coherency ? 4'hF : ~lock;
        end
    end
    assign inval_any = size_change || PROG_CYCLE_I;

    // lookup in the half that matches the access kind
    assign look_tag = FETCH_ADDR_I[31:2];
    always_comb begin
        cache_hit  = 1'b0;
        cache_word = 32'h0000_0000;
        for (int i = 0; i < NLINES; i++) begin
            if (line_hit[i] && (FETCH_DATA_I == (i >= ILINES)) &&
                (i < ILINES || data_en[i - ILINES])) begin
                cache_hit  = 1'b1;
                cache_word = line_data[i];
            end
        end
    end
    assign pf_hit     = pf_valid && (pf_tag == look_tag);
    assign can_cache  = FETCH_CACHEABLE_I && (!FETCH_DATA_I || dsize != DSIZE_OFF);
    assign pf_allowed = FETCH_CACHEABLE_I ? pfsel[0] : pfsel[1];

    // a new request is never taken in a cycle that invalidates
    assign accept = (state == ST_IDLE) && FETCH_REQ_I && !FETCH_READY_O && !inval_any;
    assign flash_start = accept && !cache_hit && !pf_hit;

    // fill strobes for the line picked by the round-robin pointers
    always_comb begin
        fill_vec = '0;
        if (state == ST_FILL && flash_done && miss_cache && !inval_any) begin
            if (miss_data) begin
                fill_vec[ILINES + 32'(dptr)] = 1'b1;
            end else if (!lock[iptr]) begin
                fill_vec[iptr] = 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NLINES; g++) begin : gen_line
            cache_line_slot #(
                .TW (TAG_W),
                .DW (WORD_W)
            ) u_line (
                .clk_i   (CLOCK_I),
                .rst_n_i (RSTN_I),
                .inval_i (inval_vec[g]),
                .fill_i  (fill_vec[g]),
                .tag_i   (miss_tag),
                .data_i  (FLASH_RDATA_I),
                .look_i  (look_tag),
                .valid_o (line_valid[g]),
                .hit_o   (line_hit[g]),
                .data_o  (line_data[g])
            );
        end
    endgenerate

    flash_wait_timer u_timer (
        .clk_i   (CLOCK_I),
        .rst_n_i (RSTN_I),
        .start_i (flash_start || (state == ST_FILL && flash_done && miss_pf && !inval_any)),
        .abort_i (inval_any),
        .wait_i  (wait_cnt),
        .busy_o  (),
        .done_o  (flash_done)
    );

    // fetch state machine
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (flash_start) begin
                        state <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    if (inval_any) begin
                        state <= ST_IDLE;
                    end else if (flash_done) begin
                        state <= miss_pf ? ST_PREFETCH : ST_IDLE;
                    end
                end
                ST_PREFETCH: begin
                    if (inval_any || flash_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // miss bookkeeping captured when a flash read starts
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            miss_tag   <= '0;
            miss_data  <= 1'b0;
            miss_cache <= 1'b0;
            miss_pf    <= 1'b0;
        end else if (flash_start) begin
            miss_tag   <= look_tag;
            miss_data  <= FETCH_DATA_I;
            miss_cache <= can_cache;
            miss_pf    <= pf_allowed;
        end
    end

    // flash port; address steps to the next word for a prefetch
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I || inval_any) begin
            FLASH_REQ_O  <= 1'b0;
            FLASH_ADDR_O <= 32'h0000_0000;
        end else if (flash_start) begin
            FLASH_REQ_O  <= 1'b1;
            FLASH_ADDR_O <= {look_tag, 2'b00};
        end else if (state == ST_FILL && flash_done && miss_pf) begin
            FLASH_ADDR_O <= {miss_tag + TAG_ONE, 2'b00};
        end else if (flash_done) begin
            FLASH_REQ_O  <= 1'b0;
        end
    end

    // answer to the core: hits one cycle after the request is taken, misses at the end of the fill
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            FETCH_READY_O <= 1'b0;
            FETCH_RDATA_O <= 32'h0000_0000;
        end else if (accept && (cache_hit || pf_hit)) begin
            FETCH_READY_O <= 1'b1;
            FETCH_RDATA_O <= cache_hit ? cache_word : pf_data;
        end else if (state == ST_FILL && flash_done && !inval_any) begin
            FETCH_READY_O <= 1'b1;
            FETCH_RDATA_O <= FLASH_RDATA_I;
        end else begin
            FETCH_READY_O <= 1'b0;
        end
    end

    // prefetch buffer; a stale prefetched word would bypass line invalidation
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I || inval_any) begin
            pf_valid <= 1'b0;
        end else if (state == ST_PREFETCH && flash_done) begin
            pf_valid <= 1'b1;
            pf_tag   <= FLASH_ADDR_O[31:2];
            pf_data  <= FLASH_RDATA_I;
        end
    end

    // round-robin victims; data pointer wraps at the enabled line count
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I || size_change) begin
            iptr <= 2'h0;
            dptr <= 2'h0;
        end else if (|fill_vec) begin
            if (!miss_data) begin
                iptr <= iptr + 2'h1;
            end else if (data_en[dptr + 2'h1] && dptr != 2'h3) begin
                dptr <= dptr + 2'h1;
            end else begin
                dptr <= 2'h0;
            end
        end
    end
endmodule

// ### verification/flash_memory_model.sv
// Purpose: behavioural program flash answering the cache's read port
// Assumes: the access ends on the cycle that the wait count names
// Notes:   words show only in the last cycle of an access
`timescale 1ns/1ns
module flash_memory_model (
    input  wire logic        clk_i,    // system clock
    input  wire logic        req_i,    // read in progress
    input  wire logic [31:0] addr_i,   // byte address
    input  wire logic [2:0]  wait_i,   // wait states now set
    output logic [31:0]      rdata_o   // read data
);
    logic        last_req  = 1'b0;
    logic [31:0] last_addr = 32'h0;
    logic [2:0]  age       = 3'h0;
    logic [31:0] hold      = 32'h0;
    logic [2:0]  cur_age;

    // a new address restarts the access, so its word is late again
    assign cur_age = (!last_req || addr_i != last_addr) ? 3'h0 : age;

    // track the access age and the last value shown
    always_ff @(posedge clk_i) begin
        last_req  <= req_i;
        last_addr <= addr_i;
        age       <= (cur_age == 3'h7) ? 3'h7 : cur_age + 3'h1;
        hold      <= rdata_o;
    end

    // early or idle cycles show a value that flips every cycle, never the word
    always_comb begin
        if (req_i && cur_age >= wait_i)
            rdata_o = {~addr_i[15:0], addr_i[15:0]};
        else
            rdata_o = ~hold;
    end
endmodule

// ### verification/flash_prefetch_cache_assertions.sv
// Purpose: port level checks of the flash prefetch cache
// Assumes: control writes are visible on the apb lines, so a shadow follows them
// Notes:   bound from the testbench top file
`timescale 1ns/1ns
module flash_prefetch_cache_assertions (
    input wire logic        CLOCK_I,        // system clock
    input wire logic        RSTN_I,         // reset, active low
    input wire logic        PSEL_I,         // apb select
    input wire logic        PENABLE_I,      // apb access
    input wire logic        PWRITE_I,       // apb direction
    input wire logic [7:0]  PADDR_I,        // apb address
    input wire logic [31:0] PWDATA_I,       // apb write data
    input wire logic [31:0] PRDATA_O,       // apb read data
    input wire logic        PREADY_O,       // apb ready
    input wire logic        PSLVERR_O,      // apb error
    input wire logic        FETCH_READY_O,  // fetch answer
    input wire logic        FLASH_REQ_O,    // flash read
    input wire logic [31:0] FLASH_ADDR_O,   // flash address
    input wire logic        PROG_CYCLE_I    // program cycle
);
    import flash_cache_pkg::*;
    logic [31:0] shadow;
    logic [3:0]  since;
    logic        prev_req;
    logic [31:0] prev_addr;
    logic        ctrl_wr;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);

    // a control write takes effect at the edge where ready is seen
    assign ctrl_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == CTRL_OFFSET;

    // shadow of the control register
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I)
            shadow <= CTRL_RESET;
        else if (ctrl_wr)
            shadow <= PWDATA_I & CTRL_WR_MASK;
    end

    // cycles spent on the current flash address, saturating
    always_ff @(posedge CLOCK_I) begin
        prev_req  <= FLASH_REQ_O;
        prev_addr <= FLASH_ADDR_O;
        if (!RSTN_I)
            since <= 4'h0;
        else if (FLASH_REQ_O && (!prev_req || FLASH_ADDR_O != prev_addr))
            since <= 4'h1;
        else if (FLASH_REQ_O && since != 4'hF)
            since <= since + 4'h1;
    end

    chk_reset_quiet: assert property ($rose(RSTN_I) |-> !PREADY_O && !FETCH_READY_O && !FLASH_REQ_O)
        else $error("active after reset");
    chk_apb_one_wait: assert property ((PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I) |=> PREADY_O)
        else $error("ready late");
    chk_ready_single: assert property (PREADY_O |-> PSEL_I && PENABLE_I ##1 !PREADY_O)
        else $error("stray ready");
    chk_err_zero: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
        else $error("bad error answer");
    chk_ctrl_read: assert property (PREADY_O && !PWRITE_I && PADDR_I == CTRL_OFFSET |-> PRDATA_O == shadow)
        else $error("control read wrong");
    chk_prog_stall: assert property (PROG_CYCLE_I |=> !FETCH_READY_O)
        else $error("answer in program cycle");
    chk_resize_stall: assert property (ctrl_wr && PWDATA_I[9:8] != shadow[9:8] |=> !FETCH_READY_O)
        else $error("answer in size change");
    chk_miss_wait: assert property (FETCH_READY_O && $past(FLASH_REQ_O) |-> since == {1'b0, shadow[2:0]} + 4'h1)
        else $error("miss latency wrong");
endmodule

// ### verification/flash_prefetch_cache_tb.sv
// Purpose: self-checking bench of the flash prefetch cache
// Assumes: a flash model answers the read port; apb master in the bench
// Notes:   expected words come from the bench's own address pattern
`timescale 1ns/1ns
module flash_prefetch_cache_tb;
    import flash_cache_pkg::*;
    logic        CLOCK_I = 1'b0, RSTN_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
    logic [7:0]  PADDR_I = 8'h00;
    logic [31:0] PWDATA_I = 32'h0, FETCH_ADDR_I = 32'h0, PRDATA_O, FETCH_RDATA_O, FLASH_ADDR_O, FLASH_RDATA_I;
    logic        FETCH_REQ_I = 1'b0, FETCH_DATA_I = 1'b0, FETCH_CACHEABLE_I = 1'b0, PROG_CYCLE_I = 1'b0;
    logic        PREADY_O, PSLVERR_O, FETCH_READY_O, FLASH_REQ_O;
    logic [2:0]  ws_now = 3'h7;
    int          n_errors = 0, cmp_count = 0, cycles = 0;

    flash_prefetch_cache uut (.*);
    flash_memory_model flash (.clk_i(CLOCK_I), .req_i(FLASH_REQ_O), .addr_i(FLASH_ADDR_O), .wait_i(ws_now),
        .rdata_o(FLASH_RDATA_I));

    // 25 MHz system clock
    always #20 CLOCK_I = ~CLOCK_I;

    // hang guard
    always @(posedge CLOCK_I) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("BAD %0t run too long", $time);
            wrap_up;
        end
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge CLOCK_I);
        PSEL_I    <= 1'b1;
        PWRITE_I  <= w;
        PADDR_I   <= a;
        PWDATA_I  <= d;
        @(posedge CLOCK_I);
        PENABLE_I <= 1'b1;
        n = 0;
        do begin
            @(posedge CLOCK_I);
            n++;
        end while (PREADY_O !== 1'b1 && n < 20);
        r = PRDATA_O;
        e = PSLVERR_O;
        PSEL_I    <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    // fetch held until answered; pf flags a next-word read
    task automatic fetch(input logic [31:0] a, input logic dat, input logic cch, output logic [31:0] r,
                         output int n, output logic pf);
        @(posedge CLOCK_I);
        FETCH_REQ_I       <= 1'b1;
        FETCH_ADDR_I      <= a;
        FETCH_DATA_I      <= dat;
        FETCH_CACHEABLE_I <= cch;
        n = 0;
        do begin
            @(posedge CLOCK_I);
            n++;
        end while (FETCH_READY_O !== 1'b1 && n < 40);
        r  = FETCH_RDATA_O;
        pf = FLASH_REQ_O === 1'b1 && FLASH_ADDR_O === a + 32'h4;
        FETCH_REQ_I <= 1'b0;
        for (int k = 0; k < 40 && FLASH_REQ_O !== 1'b0; k++)
            @(posedge CLOCK_I);
        chk(r, {~a[15:0], a[15:0]}, "fetched word");
    endtask

    task automatic pulse_prog;
        @(posedge CLOCK_I);
        PROG_CYCLE_I <= 1'b1;
        @(posedge CLOCK_I);
        PROG_CYCLE_I <= 1'b0;
    endtask

    task automatic test_regs;
        logic [31:0] r;
        logic        e;
        apb(1'b0, CTRL_OFFSET, 32'h0, r, e);
        chk(r, 32'h0000_0007, "control after reset");
        wr(CTRL_OFFSET, 32'h0001_0337);
        apb(1'b0, CTRL_OFFSET, 32'h0, r, e);
        chk(r, 32'h0001_0337, "control fields");
        apb(1'b1, 8'h0C, 32'h0, r, e);
        chk({31'h0, e}, 32'h1, "unmapped write error");
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk({31'h0, e}, 32'h1, "unmapped read error");
        $display("register test done");
    endtask

    // uncacheable misses: answer after wait + 3 edges
    task automatic test_wait;
        logic [31:0] r;
        int          n;
        logic        pf;
        for (int w = 0; w < 8; w++) begin
            wr(CTRL_OFFSET, 32'(w));
            ws_now = 3'(w);
            fetch(32'h1000 + 32'(w * 4), 1'b0, 1'b0, r, n, pf);
            chk(32'(n), 32'(w + 3), "miss latency");
        end
        $display("wait state test done");
    endtask

    task automatic test_size;
        logic [31:0] r;
        logic        e;
        int          n;
        logic        pf;
        int          lines [4] = '{0, 1, 2, 4};
        ws_now = 3'h0;
        for (int s = 3; s >= 0; s--) begin
            wr(CTRL_OFFSET, 32'(s) << 8);
            apb(1'b0, STATUS_OFFSET, 32'h0, r, e);
            chk({24'h0, r[11:4]}, 32'h0, "lines after size change");
            for (int i = 0; i < 4; i++)
                fetch(32'h2000 + 32'(i * 4), 1'b1, 1'b1, r, n, pf);
            apb(1'b0, STATUS_OFFSET, 32'h0, r, e);
            chk(32'($countones(r[11:8])), 32'(lines[s]), "data lines in use");
        end
        $display("size test done");
    endtask

    task automatic test_prefetch;
        logic [31:0] r;
        int          n;
        logic        pf;
        for (int p = 0; p < 4; p++)
            for (int c = 0; c < 2; c++) begin
                wr(CTRL_OFFSET, 32'(p) << 4);
                fetch(32'h3000 + 32'((p * 2 + c) * 8), 1'b0, c[0], r, n, pf);
                chk({31'h0, pf}, {31'h0, c ? p[0] : p[1]}, "next word read");
            end
        $display("prefetch test done");
    endtask

    task automatic test_prog;
        logic [31:0] r;
        logic [31:0] v;
        logic        e;
        int          n;
        logic        pf;
        wr(CTRL_OFFSET, 32'h0000_0100);
        wr(LOCK_OFFSET, 32'h0);
        for (int i = 0; i < 4; i++)
            fetch(32'h4000 + 32'(i * 4), 1'b0, 1'b1, r, n, pf);
        fetch(32'h5000, 1'b1, 1'b1, r, n, pf);
        apb(1'b0, STATUS_OFFSET, 32'h0, v, e);
        wr(LOCK_OFFSET, 32'h5);
        pulse_prog;
        apb(1'b0, STATUS_OFFSET, 32'h0, r, e);
        chk({24'h0, r[11:4]}, {28'h0, v[7:4] & 4'h5}, "locked lines kept");
        wr(CTRL_OFFSET, 32'h0001_0100);
        pulse_prog;
        apb(1'b0, STATUS_OFFSET, 32'h0, r, e);
        chk({24'h0, r[11:4]}, 32'h0, "all lines dropped");
        // program cycle in mid-miss restarts the read
        wr(CTRL_OFFSET, 32'h0001_0107);
        ws_now = 3'h7;
        fork
            fetch(32'h6000, 1'b0, 1'b0, r, n, pf);
            begin
                repeat (4) @(posedge CLOCK_I);
                pulse_prog;
            end
        join
        chk({31'h0, n > 10}, 32'h1, "aborted miss restarted");
        $display("program cycle test done");
    endtask

    // reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge CLOCK_I);
        RSTN_I <= 1'b1;
        test_regs;
        test_wait;
        test_size;
        test_prefetch;
        test_prog;
        wrap_up;
    end
endmodule

bind flash_prefetch_cache flash_prefetch_cache_assertions chk_i (.*);
